// >>> sxc_cfg_bank.sv
// Purpose: Extended configuration registers with floppy setup, drive type,
//          powerdown/boot, general address decoder and parallel/serial setup
// Assumes: Host front end delivers same-clock index/data strobes
// Notes:   Address, chip select and hardware reset pins are synchronised
//
// Function
// - Registers reachable only in config mode with matching index value.
// - Floppy setup bits 0, 1, 7 read zero and are read-only.
// - Floppy setup bit 2: 0 burst DMA, 1 strobe request/interrupt per byte while fifo_en is set.
// - Bits 4:3 density: 00 normal, 01 reserved, 10 force one, 11 zero.
// - Floppy setup bit 5 swaps drive and motor selects of drives 0,1.
// - Bit 6 picks internal two-drive decode or encoded selects for external.
// - Drive type register at index 06 resets to FF.
// - Boot field bits 1:0 select drive A or B; bits 3:2 read zero.
// - Bits 4..7 enable auto powerdown: parallel, UART2, UART1, floppy.
// - Powerdown enables cleared by power-on or hardware reset.
// - Index 08 bits 7:4 give decoder address 7:4; address bits 3:0 zero.
// - Index 09 bits 2:0 give decoder address bits 10:8.
// - Index 09 bits 7:6: off, one byte, 8-byte block, 16-byte block.
// - Decoder output asserted only if chip select input was low three clocks earlier.
// - MIDI selects divide by 12 giving 125 kHz for 31.25 kbaud.
// - Combined ECP+EPP mode lets ECR mode 100 pick EPP.
// - ECP modes let ECR mode 000 pick standard parallel; two drives direct.
// - Parallel/serial setup bits 1:0 select parallel port mode.
`timescale 1ns/1ps

module sxc_cfg_bank (
    // Clock, reset, enable
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    input  wire logic                      ce,
    input  wire logic                      hw_reset_pin,
    // Configuration access
    input  wire sxc_pkg::sxc_cfg_req_t     cfg_req,
    output logic [7:0]                     cfg_rdata,
    output logic                           cfg_rvalid,
    // General decoder pins
    input  wire logic [sxc_pkg::DEC_AW-1:0] host_addr,
    input  wire logic                      chip_select_n,
    output logic                           general_decode_out,
    // Floppy core and pins
    input  wire sxc_pkg::sxc_fdc_core_t    fdc_core,
    output sxc_pkg::sxc_fdc_pins_t         fdc_pins,
    output logic [7:0]                     floppy_drive_types,
    output logic                           boot_drive_b,
    // Auto powerdown enables
    output logic                           pd_en_parallel,
    output logic                           pd_en_uart2,
    output logic                           pd_en_uart1,
    output logic                           pd_en_floppy,
    // Parallel and serial setup
    input  wire logic [2:0]                ecr_mode,
    output sxc_pkg::sxc_par_mode_t         parallel_mode,
    output logic [1:0]                     par_floppy_sel,
    output logic                           epp_type_17,
    output logic                           epp_active,
    output logic                           standard_parallel_mode,
    output logic [3:0]                     uart1_clk_div,
    output logic [3:0]                     uart2_clk_div
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops
    logic [1:0] rst_sync_reg;
    logic       rst_n_int;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_n_int = rst_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // State
    sxc_pkg::sxc_state_t st_reg;
    sxc_pkg::sxc_state_t st_next;

    // Decoded fields
    logic                  hw_rst;
    logic                  dma_nonburst;
    sxc_pkg::sxc_den_mode_t den_mode;
    logic                  swap01;
    logic                  ext4;
    sxc_pkg::sxc_dec_mode_t dec_mode;
    logic [sxc_pkg::DEC_AW-1:0] dec_base;
    logic                  dec_hit;
    logic [1:0]            drv_num_sw;
    logic [1:0]            motor_sw;
    logic [7:0]            rd_mux;
    logic                  acc_ok;

    assign hw_rst       = st_reg.hwrst_s[1];
    assign dma_nonburst = st_reg.fdd_ext[sxc_pkg::FE_DMA_BIT];
    assign den_mode     =
        sxc_pkg::sxc_den_mode_t'(st_reg.fdd_ext[sxc_pkg::FE_DEN_LSB +: 2]);
    assign swap01       = st_reg.fdd_ext[sxc_pkg::FE_SWAP_BIT];
    assign ext4         = st_reg.fdd_ext[sxc_pkg::FE_EXT4_BIT];
    assign dec_mode     =
        sxc_pkg::sxc_dec_mode_t'(st_reg.dec_hi[sxc_pkg::DH_MODE_LSB +: 2]);
    assign acc_ok       = cfg_req.cfg_mode;

    // Decoder base: bits 10:8 high reg, 7:4 low reg, 3:0 fixed zero
    assign dec_base = {st_reg.dec_hi[sxc_pkg::DH_ADDR_LSB +: 3],
                       st_reg.dec_lo[sxc_pkg::DL_ADDR_LSB +: 4],
                       4'h0};

    ////////////////////////////////////////////////////////////////////////
    // General decoder compare
    always_comb begin
        case (dec_mode)
            sxc_pkg::DM_OFF:   dec_hit = 1'b0;
            sxc_pkg::DM_BYTE:  dec_hit = (st_reg.addr_s2 == dec_base);
            sxc_pkg::DM_BLK8:  dec_hit =
                (st_reg.addr_s2[sxc_pkg::DEC_AW-1:3] ==
                 dec_base[sxc_pkg::DEC_AW-1:3]);
            sxc_pkg::DM_BLK16: dec_hit =
                (st_reg.addr_s2[sxc_pkg::DEC_AW-1:4] ==
                 dec_base[sxc_pkg::DEC_AW-1:4]);
            default:           dec_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Drive and motor swap for drives 0 and 1
    always_comb begin
        drv_num_sw = fdc_core.drv_num;
        if (swap01 && !fdc_core.drv_num[1]) begin
            drv_num_sw = {1'b0, ~fdc_core.drv_num[0]};
        end
        motor_sw = swap01 ? {fdc_core.motor[0], fdc_core.motor[1]}
                          : fdc_core.motor;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read multiplexer; reserved bits masked to zero
    always_comb begin
        case (st_reg.index)
            sxc_pkg::IDX_PAR_SER:
                rd_mux = st_reg.par_ser & sxc_pkg::MASK_PAR_SER;
            sxc_pkg::IDX_FDD_EXT:
                rd_mux = st_reg.fdd_ext & sxc_pkg::MASK_FDD_EXT;
            sxc_pkg::IDX_DRV_TYPE:
                rd_mux = st_reg.drv_type;
            sxc_pkg::IDX_PWR_BOOT:
                rd_mux = st_reg.pwr_boot & sxc_pkg::MASK_PWR_BOOT;
            sxc_pkg::IDX_DEC_LO:
                rd_mux = st_reg.dec_lo;
            sxc_pkg::IDX_DEC_HI:
                rd_mux = st_reg.dec_hi;
            default:
                rd_mux = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_next = st_reg;

        // Pin synchronisers
        st_next.addr_s1 = host_addr;
        st_next.addr_s2 = st_reg.addr_s1;
        st_next.cs_n_s  = {st_reg.cs_n_s[0], chip_select_n};
        st_next.hwrst_s = {st_reg.hwrst_s[0], hw_reset_pin};

        // Configuration access
        st_next.rvalid = 1'b0;
        if (acc_ok && cfg_req.idx_wr) begin
            st_next.index = cfg_req.wdata;
        end
        if (acc_ok && cfg_req.data_rd) begin
            st_next.rdata  = rd_mux;
            st_next.rvalid = 1'b1;
        end
        if (acc_ok && cfg_req.data_wr) begin
            case (st_reg.index)
                sxc_pkg::IDX_PAR_SER:
                    st_next.par_ser = cfg_req.wdata & sxc_pkg::MASK_PAR_SER;
                sxc_pkg::IDX_FDD_EXT:
                    st_next.fdd_ext =
                        cfg_req.wdata & sxc_pkg::MASK_FDD_EXT;
                sxc_pkg::IDX_DRV_TYPE:
                    st_next.drv_type = cfg_req.wdata;
                sxc_pkg::IDX_PWR_BOOT:
                    st_next.pwr_boot =
                        cfg_req.wdata & sxc_pkg::MASK_PWR_BOOT;
                sxc_pkg::IDX_DEC_LO:
                    st_next.dec_lo = cfg_req.wdata;
                sxc_pkg::IDX_DEC_HI:
                    st_next.dec_hi = cfg_req.wdata;
                default: begin
                end
            endcase
        end

        // Decoder output qualified by chip select
        st_next.dec_out = dec_hit && !st_reg.cs_n_s[1];

        // Floppy request strobing
        if (dma_nonburst && fdc_core.fifo_en) begin
            st_next.fdc.dma_req = fdc_core.byte_strobe;
            st_next.fdc.int_req = fdc_core.byte_strobe;
        end else begin
            st_next.fdc.dma_req = fdc_core.drq;
            st_next.fdc.int_req = fdc_core.irq;
        end

        // Density select override
        case (den_mode)
            sxc_pkg::DN_ONE:  st_next.fdc.density = 1'b1;
            sxc_pkg::DN_ZERO: st_next.fdc.density = 1'b0;
            default:          st_next.fdc.density = fdc_core.density;
        endcase

        // Drive select: one-hot for two drives or encoded for four
        st_next.fdc.enc_mode = ext4;
        st_next.fdc.motor    = motor_sw;
        if (ext4) begin
            st_next.fdc.drv_sel = fdc_core.drv_active ? drv_num_sw
                                                      : 2'b00;
        end else begin
            st_next.fdc.drv_sel = 2'b00;
            if (fdc_core.drv_active && !drv_num_sw[1]) begin
                st_next.fdc.drv_sel[drv_num_sw[0]] = 1'b1;
            end
        end

        // ECP register mode selection
        st_next.epp_sel = (sxc_pkg::sxc_par_mode_t'(
            st_reg.par_ser[sxc_pkg::PS_MODE_LSB +: 2]) == sxc_pkg::PM_EPP) ||
            ((sxc_pkg::sxc_par_mode_t'(
            st_reg.par_ser[sxc_pkg::PS_MODE_LSB +: 2]) ==
            sxc_pkg::PM_ECP_EPP) && (ecr_mode == sxc_pkg::ECR_EPP));
        st_next.std_sel = (st_reg.par_ser[sxc_pkg::PS_MODE_LSB + 1] &&
            (ecr_mode == sxc_pkg::ECR_STD)) ||
            !st_reg.par_ser[sxc_pkg::PS_MODE_LSB + 1];

        // Hardware reset returns the bank to its defaults
        if (hw_rst) begin
            st_next.index    = sxc_pkg::RST_INDEX;
            st_next.par_ser  = sxc_pkg::RST_PAR_SER;
            st_next.fdd_ext  = sxc_pkg::RST_FDD_EXT;
            st_next.drv_type = sxc_pkg::RST_DRV_TYPE;
            st_next.pwr_boot = sxc_pkg::RST_PWR_BOOT;
            st_next.dec_lo   = sxc_pkg::RST_DEC_LO;
            st_next.dec_hi   = sxc_pkg::RST_DEC_HI;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; ce freezes everything
    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            st_reg          <= '0;
            st_reg.index    <= sxc_pkg::RST_INDEX;
            st_reg.par_ser  <= sxc_pkg::RST_PAR_SER;
            st_reg.fdd_ext  <= sxc_pkg::RST_FDD_EXT;
            st_reg.drv_type <= sxc_pkg::RST_DRV_TYPE;
            st_reg.pwr_boot <= sxc_pkg::RST_PWR_BOOT;
            st_reg.dec_lo   <= sxc_pkg::RST_DEC_LO;
            st_reg.dec_hi   <= sxc_pkg::RST_DEC_HI;
            st_reg.cs_n_s   <= 2'b11;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign cfg_rdata          = st_reg.rdata;
    assign cfg_rvalid         = st_reg.rvalid;
    assign general_decode_out = st_reg.dec_out;
    assign fdc_pins           = st_reg.fdc;
    assign floppy_drive_types = st_reg.drv_type;
    assign boot_drive_b       = st_reg.pwr_boot[sxc_pkg::PB_BOOT_LSB];

    assign pd_en_parallel = st_reg.pwr_boot[sxc_pkg::PB_PD_LSB];
    assign pd_en_uart2    = st_reg.pwr_boot[sxc_pkg::PB_PD_LSB + 1];
    assign pd_en_uart1    = st_reg.pwr_boot[sxc_pkg::PB_PD_LSB + 2];
    assign pd_en_floppy   = st_reg.pwr_boot[sxc_pkg::PB_PD_LSB + 3];

    assign parallel_mode = sxc_pkg::sxc_par_mode_t'(
        st_reg.par_ser[sxc_pkg::PS_MODE_LSB +: 2]);
    assign par_floppy_sel         = st_reg.par_ser[sxc_pkg::PS_PPFD_LSB +: 2];
    assign epp_type_17            = st_reg.par_ser[sxc_pkg::PS_EPPT_BIT];
    assign epp_active             = st_reg.epp_sel;
    assign standard_parallel_mode = st_reg.std_sel;

    // Baud source divisor: 24 MHz / 12 / 16 = 125 kHz for MIDI
    assign uart1_clk_div = st_reg.par_ser[sxc_pkg::PS_MIDI1_BIT]
                           ? sxc_pkg::DIV_MIDI : sxc_pkg::DIV_STD;
    assign uart2_clk_div = st_reg.par_ser[sxc_pkg::PS_MIDI2_BIT]
                           ? sxc_pkg::DIV_MIDI : sxc_pkg::DIV_STD;

endmodule

// >>> sxc_cfg_bank_asserts.sv
// Purpose: Port-level checks of the configuration bank
// Assumes: Single clock, reset low on rst_b
// Notes:   Bound to every instance of the bank
`timescale 1ns/1ps

module sxc_cfg_bank_chk (
    // Clock and reset
    input wire logic                   clk,
    input wire logic                   rst_b,
    input wire logic                   hw_reset_pin,
    // Configuration access
    input wire sxc_pkg::sxc_cfg_req_t  cfg_req,
    input wire logic                   cfg_rvalid,
    // Decoder
    input wire logic                   chip_select_n,
    input wire logic                   general_decode_out,
    // Floppy and auto powerdown
    input wire sxc_pkg::sxc_fdc_core_t fdc_core,
    input wire sxc_pkg::sxc_fdc_pins_t fdc_pins,
    input wire logic [7:0]             floppy_drive_types,
    input wire logic                   pd_en_parallel,
    input wire logic                   pd_en_uart2,
    input wire logic                   pd_en_uart1,
    input wire logic                   pd_en_floppy,
    // Parallel and serial
    input wire logic [2:0]             ecr_mode,
    input wire sxc_pkg::sxc_par_mode_t parallel_mode,
    input wire logic                   epp_active,
    input wire logic                   standard_parallel_mode,
    input wire logic [3:0]             uart1_clk_div,
    input wire logic [3:0]             uart2_clk_div
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_read_answer: assert property (cfg_req.cfg_mode && cfg_req.data_rd
        |=> cfg_rvalid) else $error("read not answered");
    a_read_source: assert property (cfg_rvalid
        |-> $past(cfg_req.cfg_mode) && $past(cfg_req.data_rd))
        else $error("answer without read");
    a_decode_cs: assert property (general_decode_out
        |-> !$past(chip_select_n, 3)) else $error("decode without cs");
    a_midi_div: assert property ((uart1_clk_div == 4'hC
        || uart1_clk_div == 4'hD) && (uart2_clk_div == 4'hC
        || uart2_clk_div == 4'hD)) else $error("bad divisor");
    a_epp_select: assert property (epp_active |-> $past(parallel_mode)
        == 2'h1 || ($past(parallel_mode) == 2'h3 && $past(ecr_mode) == 3'h4))
        else $error("epp without cause");
    a_std_select: assert property (standard_parallel_mode
        |-> $past(parallel_mode) < 2'h2 || $past(ecr_mode) == 3'h0)
        else $error("standard without cause");
    a_hw_reset: assert property ($rose(hw_reset_pin) |-> ##[2:4]
        (!pd_en_parallel && !pd_en_uart2 && !pd_en_uart1 && !pd_en_floppy
        && floppy_drive_types == 8'hFF)) else $error("hw reset missed");
    a_select_internal: assert property (!fdc_pins.enc_mode
        |-> fdc_pins.drv_sel != 2'h3) else $error("bad internal select");
    a_dma_cause: assert property (fdc_pins.dma_req
        |-> $past(fdc_core.drq) || $past(fdc_core.byte_strobe))
        else $error("dma without cause");

    c_read: cover property (cfg_rvalid);
    c_decode: cover property (general_decode_out);
    c_epp: cover property (epp_active);
    c_hw: cover property ($rose(hw_reset_pin));
endmodule

bind sxc_cfg_bank sxc_cfg_bank_chk chk (.clk(clk), .rst_b(rst_b),
    .hw_reset_pin(hw_reset_pin), .cfg_req(cfg_req), .cfg_rvalid(cfg_rvalid),
    .chip_select_n(chip_select_n), .general_decode_out(general_decode_out),
    .fdc_core(fdc_core), .fdc_pins(fdc_pins),
    .floppy_drive_types(floppy_drive_types), .pd_en_parallel(pd_en_parallel),
    .pd_en_uart2(pd_en_uart2), .pd_en_uart1(pd_en_uart1),
    .pd_en_floppy(pd_en_floppy), .ecr_mode(ecr_mode),
    .parallel_mode(parallel_mode), .epp_active(epp_active),
    .standard_parallel_mode(standard_parallel_mode),
    .uart1_clk_div(uart1_clk_div), .uart2_clk_div(uart2_clk_div));

// >>> sxc_host_model.sv
// Purpose: Host side of the configuration access path
// Assumes: Same-clock strobes, index written before each data cycle
// Notes:   mode drops config mode for refused accesses
`timescale 1ns/1ps

module sxc_host_model (
    // Clock
    input  wire logic                  clk,
    // Configuration access
    output sxc_pkg::sxc_cfg_req_t      cfg_req,
    input  wire logic [7:0]            cfg_rdata,
    input  wire logic                  cfg_rvalid
);
    logic mode = 1'b1;

    initial cfg_req = '0;

    // One strobe, held for exactly one sampling edge
    task automatic op(input logic [2:0] s, input logic [7:0] d);
        @(posedge clk);
        cfg_req <= {mode, s, d};
        @(posedge clk);
        cfg_req <= '0;
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        op(3'h4, i);
        op(3'h2, d);
    endtask

    task automatic rd(input logic [7:0] i, output logic [7:0] d);
        op(3'h4, i);
        op(3'h1, 8'h00);
        @(negedge clk);
        d = cfg_rvalid ? cfg_rdata : 8'hXX;
    endtask
endmodule

// >>> sxc_pkg.sv
// Purpose: Shared constants and types for the extended configuration bank
// Assumes: Eight-bit index/data configuration access on one clock
// Notes:   Indices, masks, field positions and resets are named once here
package sxc_pkg;

    // Register indices
    localparam logic [7:0] IDX_PAR_SER  = 8'h04;
    localparam logic [7:0] IDX_FDD_EXT  = 8'h05;
    localparam logic [7:0] IDX_DRV_TYPE = 8'h06;
    localparam logic [7:0] IDX_PWR_BOOT = 8'h07;
    localparam logic [7:0] IDX_DEC_LO   = 8'h08;
    localparam logic [7:0] IDX_DEC_HI   = 8'h09;

    // Reset values
    localparam logic [7:0] RST_PAR_SER  = 8'h00;
    localparam logic [7:0] RST_FDD_EXT  = 8'h00;
    localparam logic [7:0] RST_DRV_TYPE = 8'hFF;
    localparam logic [7:0] RST_PWR_BOOT = 8'h00;
    localparam logic [7:0] RST_DEC_LO   = 8'h00;
    localparam logic [7:0] RST_DEC_HI   = 8'h00;
    localparam logic [7:0] RST_INDEX    = 8'h00;

    // Writable bits; the rest are reserved and read zero
    localparam logic [7:0] MASK_PAR_SER  = 8'h7F;
    localparam logic [7:0] MASK_FDD_EXT  = 8'h7C;
    localparam logic [7:0] MASK_DRV_TYPE = 8'hFF;
    localparam logic [7:0] MASK_PWR_BOOT = 8'hF3;
    localparam logic [7:0] MASK_DEC_LO   = 8'hFF;
    localparam logic [7:0] MASK_DEC_HI   = 8'hFF;

    // Field positions
    localparam int PS_MODE_LSB   = 0;
    localparam int PS_PPFD_LSB   = 2;
    localparam int PS_MIDI1_BIT  = 4;
    localparam int PS_MIDI2_BIT  = 5;
    localparam int PS_EPPT_BIT   = 6;
    localparam int FE_DMA_BIT    = 2;
    localparam int FE_DEN_LSB    = 3;
    localparam int FE_SWAP_BIT   = 5;
    localparam int FE_EXT4_BIT   = 6;
    localparam int PB_BOOT_LSB   = 0;
    localparam int PB_PD_LSB     = 4;
    localparam int DL_ADDR_LSB   = 4;
    localparam int DH_ADDR_LSB   = 0;
    localparam int DH_MODE_LSB   = 6;

    // Serial clock divisors from the 24 MHz source
    localparam int          SRC_CLK_HZ    = 24_000_000;
    localparam logic [3:0]  DIV_MIDI      = 4'hC;
    localparam logic [3:0]  DIV_STD       = 4'hD;
    localparam int          UART_OVERSAMP = 16;
    localparam int          MIDI_CLK_HZ   = SRC_CLK_HZ / 12 / UART_OVERSAMP;

    // ECP extended control modes
    localparam logic [2:0] ECR_STD = 3'h0;
    localparam logic [2:0] ECR_EPP = 3'h4;

    localparam int DEC_AW = 11;

    typedef enum logic [1:0] {
        PM_STD     = 2'b00,
        PM_EPP     = 2'b01,
        PM_ECP     = 2'b10,
        PM_ECP_EPP = 2'b11
    } sxc_par_mode_t;

    typedef enum logic [1:0] {
        DM_OFF   = 2'b00,
        DM_BYTE  = 2'b01,
        DM_BLK8  = 2'b10,
        DM_BLK16 = 2'b11
    } sxc_dec_mode_t;

    typedef enum logic [1:0] {
        DN_NORMAL = 2'b00,
        DN_RSVD   = 2'b01,
        DN_ONE    = 2'b10,
        DN_ZERO   = 2'b11
    } sxc_den_mode_t;

    // Configuration access from the host front end
    typedef struct packed {
        logic       cfg_mode;
        logic       idx_wr;
        logic       data_wr;
        logic       data_rd;
        logic [7:0] wdata;
    } sxc_cfg_req_t;

    // Signals from the floppy core
    typedef struct packed {
        logic       drq;
        logic       irq;
        logic       byte_strobe;
        logic       fifo_en;
        logic       density;
        logic       drv_active;
        logic [1:0] drv_num;
        logic [1:0] motor;
    } sxc_fdc_core_t;

    // Signals to the floppy pins
    typedef struct packed {
        logic       dma_req;
        logic       int_req;
        logic       density;
        logic       enc_mode;
        logic [1:0] drv_sel;
        logic [1:0] motor;
    } sxc_fdc_pins_t;

    typedef struct packed {
        logic [7:0]        index;
        logic [7:0]        par_ser;
        logic [7:0]        fdd_ext;
        logic [7:0]        drv_type;
        logic [7:0]        pwr_boot;
        logic [7:0]        dec_lo;
        logic [7:0]        dec_hi;
        logic [7:0]        rdata;
        logic              rvalid;
        logic [DEC_AW-1:0] addr_s1;
        logic [DEC_AW-1:0] addr_s2;
        logic [1:0]        cs_n_s;
        logic [1:0]        hwrst_s;
        logic              dec_out;
        sxc_fdc_pins_t     fdc;
        logic              epp_sel;
        logic              std_sel;
    } sxc_state_t;

endpackage

// >>> test_sxc_cfg_bank.sv
// Purpose: Self-checking bench of the configuration bank
// Assumes: Host model gives config accesses
// Notes:   Floppy core, decoder pins and ecr are driven here
`timescale 1ns/1ps

module test_sxc_cfg_bank;
    logic                        clk;
    logic                        rst_b;
    logic                        hw_reset_pin;
    sxc_pkg::sxc_cfg_req_t       cfg_req;
    logic [7:0]                  cfg_rdata;
    logic                        cfg_rvalid;
    logic [sxc_pkg::DEC_AW-1:0]  host_addr;
    logic                        chip_select_n;
    logic                        dec_out;
    sxc_pkg::sxc_fdc_core_t      fdc_core;
    sxc_pkg::sxc_fdc_core_t      c;
    sxc_pkg::sxc_fdc_pins_t      pins;
    logic [7:0]                  types;
    logic                        boot_b;
    logic [3:0]                  pd;
    logic [2:0]                  ecr_mode;
    sxc_pkg::sxc_par_mode_t      pmode;
    logic                        epp;
    logic                        std_par;
    logic                        ept;
    logic [1:0]                  fsel;
    logic [3:0]                  div1;
    logic [3:0]                  div2;
    logic [7:0]                  v;
    logic [7:0]                  msk [6] = '{8'h7F, 8'h7C, 8'hFF, 8'hF3,
                                             8'hFF, 8'hFF};
    int                          failures;
    int                          checks;

    sxc_host_model host (.clk(clk), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid));

    sxc_cfg_bank uut (.clk(clk), .rst_b(rst_b), .ce(1'b1),
        .hw_reset_pin(hw_reset_pin), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .host_addr(host_addr),
        .chip_select_n(chip_select_n), .general_decode_out(dec_out),
        .fdc_core(fdc_core), .fdc_pins(pins), .floppy_drive_types(types),
        .boot_drive_b(boot_b), .pd_en_parallel(pd[0]), .pd_en_uart2(pd[1]),
        .pd_en_uart1(pd[2]), .pd_en_floppy(pd[3]), .ecr_mode(ecr_mode),
        .parallel_mode(pmode), .par_floppy_sel(fsel), .epp_type_17(ept),
        .epp_active(epp), .standard_parallel_mode(std_par),
        .uart1_clk_div(div1), .uart2_clk_div(div2));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk8({7'h0, g}, {7'h0, e});
    endtask
    // Core inputs land; byte strobe lasts one cycle
    task automatic fd;
        @(posedge clk);
        fdc_core <= c;
        @(posedge clk);
        fdc_core.byte_strobe <= 1'b0;
        @(negedge clk);
    endtask
    task automatic dec(input logic [1:0] m, input logic [10:0] a,
                       input logic cs, input logic e);
        host.wr(8'h09, {m, 6'h05});
        @(posedge clk);
        host_addr <= a;
        chip_select_n <= cs;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk1(dec_out, e);
    endtask

    task automatic final_report;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #300us;
        failures++;
        final_report;
    end

    initial begin
        rst_b = 1'b0;
        hw_reset_pin = 1'b0;
        host_addr = '0;
        chip_select_n = 1'b1;
        fdc_core = '0;
        ecr_mode = 3'h0;
        failures = 0;
        checks = 0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            host.rd(8'(4 + i), v);
            chk8(v, i == 2 ? 8'hFF : 8'h00);
        end
        for (int i = 0; i < 6; i++) begin
            host.wr(8'(4 + i), 8'hFF);
            host.rd(8'(4 + i), v);
            chk8(v, msk[i]);
        end
        host.wr(8'h0A, 8'h55);
        host.rd(8'h0A, v);
        chk8(v, 8'h00);
        host.mode = 1'b0;
        host.wr(8'h06, 8'h00);
        host.mode = 1'b1;
        host.rd(8'h06, v);
        chk8(v, 8'hFF);
        $display("test registers done");
        host.wr(8'h07, 8'hF1);
        @(negedge clk);
        chk8({3'h0, boot_b, pd}, 8'h1F);
        host.wr(8'h06, 8'h12);
        @(posedge clk);
        hw_reset_pin <= 1'b1;
        @(posedge clk);
        hw_reset_pin <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk8({4'h0, pd}, 8'h00);
        chk8(types, 8'hFF);
        $display("test powerdown done");
        for (int k = 0; k < 8; k++) begin
            host.wr(8'h05, {3'h0, k[1:0], 3'h0});
            c = '0;
            c.density = k[2];
            fd;
            chk1(pins.density, k[1:0] == 2 ? 1'b1 :
                 k[1:0] == 3 ? 1'b0 : k[2]);
        end
        c = '0;
        c.drv_active = 1'b1;
        c.motor = 2'h1;
        fd;
        chk8({3'h0, pins.enc_mode, pins.drv_sel, pins.motor}, 8'h05);
        host.wr(8'h05, 8'h20);
        fd;
        chk8({3'h0, pins.enc_mode, pins.drv_sel, pins.motor}, 8'h0A);
        host.wr(8'h05, 8'h40);
        c.drv_num = 2'h2;
        fd;
        chk8({3'h0, pins.enc_mode, pins.drv_sel, pins.motor}, 8'h19);
        host.wr(8'h05, 8'h04);
        c = '0;
        c.fifo_en = 1'b1;
        c.drq = 1'b1;
        c.irq = 1'b1;
        fd;
        chk8({6'h0, pins.dma_req, pins.int_req}, 8'h00);
        c.byte_strobe = 1'b1;
        fd;
        chk8({6'h0, pins.dma_req, pins.int_req}, 8'h03);
        host.wr(8'h05, 8'h00);
        c.byte_strobe = 1'b0;
        fd;
        chk8({6'h0, pins.dma_req, pins.int_req}, 8'h03);
        $display("test floppy done");
        host.wr(8'h08, 8'h50);
        dec(2'h1, 11'h550, 1'b0, 1'b1);
        dec(2'h1, 11'h551, 1'b0, 1'b0);
        dec(2'h1, 11'h550, 1'b1, 1'b0);
        dec(2'h2, 11'h557, 1'b0, 1'b1);
        dec(2'h2, 11'h558, 1'b0, 1'b0);
        dec(2'h3, 11'h55F, 1'b0, 1'b1);
        dec(2'h3, 11'h540, 1'b0, 1'b0);
        dec(2'h3, 11'h150, 1'b0, 1'b0);
        dec(2'h0, 11'h550, 1'b0, 1'b0);
        $display("test decoder done");
        for (int m = 0; m < 8; m++) begin
            v = {1'b0, m[0], 2'h3, m[2:1], m[1:0]};
            host.wr(8'h04, v);
            @(posedge clk);
            ecr_mode <= m[2] ? 3'h4 : 3'h0;
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk8({3'h0, ept, fsel, pmode}, {3'h0, v[6], v[3:0]});
            chk1(epp, m[1:0] == 1 || (m[1:0] == 3 && m[2]));
            chk1(std_par, !m[1] || !m[2]);
            chk8({div1, div2}, 8'hCC);
        end
        host.wr(8'h04, 8'h00);
        @(negedge clk);
        chk8({div1, div2}, 8'hDD);
        $display("test parallel done");
        final_report;
    end
endmodule
